/* File: dsr_map.svh */
`ifndef DSR_MAP_SVH
`define DSR_MAP_SVH

// register numbers of the status bank
`define DSR_OFF_CELL_OSC 8'h09
`define DSR_OFF_WIRE_OSC 8'h0A
`define DSR_OFF_MEM_SIZE 8'h0C
`define DSR_OFF_SSR 8'h10
`define DSR_OFF_SPC 8'h11
`define DSR_OFF_SSP 8'h12
`define DSR_OFF_TSEL 8'h13
`define DSR_OFF_RSEL 8'h14
`define DSR_OFF_CAUSE 8'h15
`define DSR_OFF_DATA 8'h16
`define DSR_OFF_HOLD 8'h18
`define DSR_OFF_SCR_BASE 8'h20
`define DSR_OFF_IBA_BASE 8'h30
`define DSR_OFF_IBC_BASE 8'h40

// field layout
`define DSR_OSC_W 16
`define DSR_SSR_WR_MASK 32'h0000_06DF
`define DSR_SSR_CAP_MASK 32'h0000_07DF
`define DSR_TSEL_W 8
`define DSR_RSEL_W 5
`define DSR_IBC_MASK 32'h00FF_0003
`define DSR_IBC_ARM 0
`define DSR_IBC_NEQ 1
`define DSR_IBC_THR_LSB 16

// cause codes
`define DSR_CAUSE_NONE 3'h0
`define DSR_CAUSE_HOST 3'h1
`define DSR_CAUSE_DEBUG_CALL_INSTRUCTION 3'h2
`define DSR_CAUSE_IBRK 3'h3
`define DSR_CAUSE_DWATCH 3'h4
`define DSR_CAUSE_RWATCH 3'h5

// reset and fixed values
`define DSR_RESET_WORD 32'h0000_0000
`define DSR_MEM_BYTES 32'h0001_0000

`endif

/* File: dsr_pkg.sv */
package dsr_pkg;

   // status-register access from the core
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [31:0] wdata;
   } dsr_ps_req_s;

   // interrupted thread context at debug entry
   typedef struct packed {
      logic [31:0] status;
      logic [31:0] pc;
      logic [31:0] sp;
      logic [7:0] thread;
   } dsr_ctx_s;

   // watchpoint report
   typedef struct packed {
      logic valid;
      logic [1:0] index;
      logic [7:0] thread;
      logic [31:0] data;
   } dsr_watch_s;

endpackage

/* File: dsr_debug_status_bank.sv */
`timescale 1ns/100ps
`include "dsr_map.svh"
module dsr_debug_status_bank
   import dsr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire dsr_ps_req_s ps_req,
   output logic [31:0] ps_rdata,
   input wire logic in_debug,
   input wire logic [1:0] osc_pin,
   input wire dsr_ctx_s entry_ctx,
   input wire logic host_dbg_req,
   input wire logic debug_call_instruction_req,
   input wire logic [7:0] debug_call_instruction_thread,
   input wire logic exec_valid,
   input wire logic [31:0] exec_pc,
   input wire logic [2:0] exec_thread,
   input wire dsr_watch_s dwatch,
   input wire dsr_watch_s rwatch,
   output logic dbg_int,
   output logic [7:0] thread_select,
   output logic [4:0] reg_select,
   output logic [7:0] thread_run_hold,
   input wire logic cfg_scr_wr,
   input wire logic [2:0] cfg_scr_idx,
   input wire logic [31:0] cfg_scr_wdata,
   output logic [31:0] cfg_scr_rdata
);

   // ****************************************
   // storage
   // ****************************************
   // oscillator synchronisers and counts
   logic [1:0] osc_s1;
   logic [1:0] osc_s2;
   logic [1:0] osc_prev;
   // power-up value only; no reset ever clears the counts
   logic [`DSR_OSC_W-1:0] osc_cnt [2] = '{default: '0};
   // debug context and cause record
   logic [31:0] saved_status_word;
   logic [31:0] saved_program_counter;
   logic [31:0] saved_stack_pointer;
   logic [2:0] cause_field;
   logic [1:0] unit_field;
   logic [7:0] cause_thread;
   logic [31:0] event_data;
   // debugger-owned words
   logic [7:0] hold_vec;
   logic [31:0] scratch [8];
   // breakpoint address and control words
   logic [31:0] ibrk_addr [4];
   logic [31:0] ibrk_ctrl [4];

   // ****************************************
   // address decode
   // ****************************************
   // writes land in debug mode only; reads are allowed at any time
   wire dbg_wr = ps_req.wr & in_debug;
   wire [7:0] a = ps_req.addr;
   wire [31:0] wd = ps_req.wdata;
   wire wr_ssr = dbg_wr & (a == `DSR_OFF_SSR);
   wire wr_spc = dbg_wr & (a == `DSR_OFF_SPC);
   wire wr_ssp = dbg_wr & (a == `DSR_OFF_SSP);
   wire wr_tsel = dbg_wr & (a == `DSR_OFF_TSEL);
   wire wr_rsel = dbg_wr & (a == `DSR_OFF_RSEL);
   wire wr_cause = dbg_wr & (a == `DSR_OFF_CAUSE);
   wire wr_data = dbg_wr & (a == `DSR_OFF_DATA);
   wire wr_hold = dbg_wr & (a == `DSR_OFF_HOLD);
   // ranges decode on the upper bits; the low bits pick the word
   wire sel_scr = ({a[7:3], 3'b000} == `DSR_OFF_SCR_BASE);
   wire sel_iba = ({a[7:2], 2'b00} == `DSR_OFF_IBA_BASE);
   wire sel_ibc = ({a[7:2], 2'b00} == `DSR_OFF_IBC_BASE);

   // ****************************************
   // ring oscillator counters
   // ****************************************
   // the oscillators are asynchronous, so edges pass two flops first;
   // a fast oscillator undercounts, fine as a random or speed source
   // osc_prev gives the rising-edge detect on the synchronised level
   always_ff @(posedge clk_sys) begin
      osc_s1 <= osc_pin;
      osc_s2 <= osc_s1;
      osc_prev <= osc_s2;
   end

   // one loop index, reused by every per-channel, per-unit and per-word loop
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_osc
         // no reset on purpose: the count survives a system reset
         always_ff @(posedge clk_sys) begin
            if (osc_s2[gi] & ~osc_prev[gi]) begin
               osc_cnt[gi] <= osc_cnt[gi] + `DSR_OSC_W'(1);
            end
         end
      end
   endgenerate

   // ****************************************
   // instruction breakpoints
   // ****************************************
   logic [3:0] bp_hit;

   generate
      for (gi = 0; gi < 4; gi++) begin : g_bp
         wire wr_a = dbg_wr & sel_iba & (a[1:0] == 2'(gi));
         wire wr_c = dbg_wr & sel_ibc & (a[1:0] == 2'(gi));
         wire eq = (exec_pc == ibrk_addr[gi]);
         // per-thread enable picked by the number of the executing thread
         wire thr_on = ibrk_ctrl[gi][`DSR_IBC_THR_LSB + exec_thread];
         // not-equal mode fires on every other pc, so it stops a thread at once
         wire cond = ibrk_ctrl[gi][`DSR_IBC_NEQ] ? ~eq : eq;
         assign bp_hit[gi] = exec_valid & ibrk_ctrl[gi][`DSR_IBC_ARM] & thr_on & cond;

         // address and control words, writable in debug mode only
         always_ff @(posedge clk_sys) begin
            if (reset) begin
               ibrk_addr[gi] <= `DSR_RESET_WORD;
               ibrk_ctrl[gi] <= `DSR_RESET_WORD;
            end else begin
               if (wr_a) begin
                  ibrk_addr[gi] <= wd;
               end
               if (wr_c) begin
                  ibrk_ctrl[gi] <= wd & `DSR_IBC_MASK;
               end
            end
         end
      end
   endgenerate

   // lowest numbered breakpoint wins
   // the index is only used when some unit hit, so 3 doubles as the fallback
   wire [1:0] bp_idx = bp_hit[0] ? 2'h0 : bp_hit[1] ? 2'h1 : bp_hit[2] ? 2'h2 : 2'h3;

   // ****************************************
   // debug entry arbitration
   // ****************************************
   // requests are ignored while already in debug mode; host first
   // nothing is queued: a request dropped before the core enters debug is lost
   wire watch_req = dwatch.valid | rwatch.valid;
   wire any_req = host_dbg_req | debug_call_instruction_req | (|bp_hit) | watch_req;
   // the pulse cycle blocks a second take before in_debug rises
   wire take = any_req & ~in_debug & ~dbg_int;

   // record values for the cause that wins this cycle
   logic [2:0] next_cause;
   logic [1:0] next_unit;
   logic [7:0] next_thread;
   logic [31:0] next_data;

   // cause, unit index, thread and data chosen together
   always_comb begin
      next_cause = `DSR_CAUSE_HOST;
      next_unit = 2'h0;
      next_thread = 8'h00;
      next_data = event_data;
      if (host_dbg_req) begin
         next_cause = `DSR_CAUSE_HOST;
      end else if (debug_call_instruction_req) begin
         next_cause = `DSR_CAUSE_DEBUG_CALL_INSTRUCTION;
         next_thread = debug_call_instruction_thread;
      end else if (|bp_hit) begin
         next_cause = `DSR_CAUSE_IBRK;
         next_unit = bp_idx;
         next_thread = {5'h00, exec_thread};
      end else if (dwatch.valid) begin
         next_cause = `DSR_CAUSE_DWATCH;
         next_unit = dwatch.index;
         next_thread = dwatch.thread;
         next_data = dwatch.data;
      end else begin
         next_cause = `DSR_CAUSE_RWATCH;
         next_unit = rwatch.index;
         next_thread = rwatch.thread;
         next_data = rwatch.data;
      end
   end

   // one-cycle interrupt pulse to the core
   // registered, so the core sees a clean pulse one edge after the take
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         dbg_int <= 1'b0;
      end else begin
         dbg_int <= take;
      end
   end

   // ****************************************
   // saved context
   // ****************************************
   // capture has priority over a debugger write in the same cycle
   // all three words are captured together, so the debugger sees one instant
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         saved_status_word <= `DSR_RESET_WORD;
         saved_program_counter <= `DSR_RESET_WORD;
         saved_stack_pointer <= `DSR_RESET_WORD;
      end else if (take) begin
         saved_status_word <= entry_ctx.status & `DSR_SSR_CAP_MASK;
         saved_program_counter <= entry_ctx.pc;
         saved_stack_pointer <= entry_ctx.sp;
      end else begin
         if (wr_ssr) begin
            // bit 8 keeps its captured value
            saved_status_word <= (wd & `DSR_SSR_WR_MASK) | (saved_status_word & ~`DSR_SSR_WR_MASK);
         end
         if (wr_spc) begin
            saved_program_counter <= wd;
         end
         if (wr_ssp) begin
            saved_stack_pointer <= wd;
         end
      end
   end

   // cause record
   // a debugger write may store any code, even ones hardware never produces
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cause_field <= `DSR_CAUSE_NONE;
         unit_field <= 2'h0;
         cause_thread <= 8'h00;
         event_data <= `DSR_RESET_WORD;
      end else if (take) begin
         cause_field <= next_cause;
         unit_field <= next_unit;
         cause_thread <= next_thread;
         event_data <= next_data;
      end else begin
         if (wr_cause) begin
            cause_field <= wd[2:0];
            unit_field <= wd[17:16];
            cause_thread <= wd[15:8];
         end
         if (wr_data) begin
            event_data <= wd;
         end
      end
   end

   // ****************************************
   // remote read selectors and run hold
   // ****************************************
   // selectors feed the remote register read directly; upper bits never stored
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         thread_select <= 8'h00;
         reg_select <= 5'h00;
         hold_vec <= 8'h00;
      end else begin
         if (wr_tsel) begin
            thread_select <= wd[`DSR_TSEL_W-1:0];
         end
         if (wr_rsel) begin
            reg_select <= wd[`DSR_RSEL_W-1:0];
         end
         if (wr_hold) begin
            hold_vec <= wd[7:0];
         end
      end
   end

   // holds only bite outside debug mode, so single stepping works
   // a held thread resumes only when its bit is cleared, a reset clears hold_vec, or debug mode is entered
   assign thread_run_hold = in_debug ? 8'h00 : hold_vec;

   // ****************************************
   // shared scratch words
   // ****************************************
   // status-port write wins over a configuration write to the same word
   // one store serves both spaces, so the two views never disagree
   generate
      for (gi = 0; gi < 8; gi++) begin : g_scr
         wire ps_hit = dbg_wr & sel_scr & (a[2:0] == 3'(gi));
         wire cfg_hit = cfg_scr_wr & (cfg_scr_idx == 3'(gi));
         always_ff @(posedge clk_sys) begin
            if (reset) begin
               scratch[gi] <= `DSR_RESET_WORD;
            end else if (ps_hit) begin
               scratch[gi] <= wd;
            end else if (cfg_hit) begin
               scratch[gi] <= cfg_scr_wdata;
            end
         end
      end
   endgenerate

   // configuration-side read, registered
   // one cycle late: the index must stand for a cycle before the data is used
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cfg_scr_rdata <= `DSR_RESET_WORD;
      end else begin
         cfg_scr_rdata <= scratch[cfg_scr_idx];
      end
   end

   // ****************************************
   // read words
   // ****************************************
   // reserved bits of the narrow registers are tied to zero here; the status word is masked where it is stored
   wire [31:0] cell_osc_word = {16'h0000, osc_cnt[0]};
   wire [31:0] wire_osc_word = {16'h0000, osc_cnt[1]};
   wire [31:0] mem_size_word = `DSR_MEM_BYTES & 32'hFFFF_FFFC;
   wire [31:0] tsel_word = {24'h000000, thread_select};
   wire [31:0] rsel_word = {27'h0000000, reg_select};
   wire [31:0] cause_word = {14'h0000, unit_field, cause_thread, 5'h00, cause_field};
   wire [31:0] hold_word = {24'h000000, hold_vec};

   // ****************************************
   // read mux
   // ****************************************
   logic [31:0] rd_word;

   // unmapped numbers and reserved bits read zero
   always_comb begin
      rd_word = `DSR_RESET_WORD;
      if (sel_scr) begin
         rd_word = scratch[a[2:0]];
      end else if (sel_iba) begin
         rd_word = ibrk_addr[a[1:0]];
      end else if (sel_ibc) begin
         rd_word = ibrk_ctrl[a[1:0]];
      end else begin
         unique case (a)
            `DSR_OFF_CELL_OSC: rd_word = cell_osc_word;
            `DSR_OFF_WIRE_OSC: rd_word = wire_osc_word;
            `DSR_OFF_MEM_SIZE: rd_word = mem_size_word;
            `DSR_OFF_SSR: rd_word = saved_status_word;
            `DSR_OFF_SPC: rd_word = saved_program_counter;
            `DSR_OFF_SSP: rd_word = saved_stack_pointer;
            `DSR_OFF_TSEL: rd_word = tsel_word;
            `DSR_OFF_RSEL: rd_word = rsel_word;
            `DSR_OFF_CAUSE: rd_word = cause_word;
            `DSR_OFF_DATA: rd_word = event_data;
            `DSR_OFF_HOLD: rd_word = hold_word;
            default: rd_word = `DSR_RESET_WORD;
         endcase
      end
   end

   // read data valid the cycle after the read strobe, held until next read
   // holding the word keeps a slow reader safe without a second strobe
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ps_rdata <= `DSR_RESET_WORD;
      end else if (ps_req.rd) begin
         ps_rdata <= rd_word;
      end
   end

endmodule // dsr_debug_status_bank

/* File: dsr_bank_checker.sv */
`timescale 1ns/100ps
`include "dsr_map.svh"
// ********
// checker
// ********
module dsr_bank_checker
   import dsr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire dsr_ps_req_s ps_req,
   input wire logic [31:0] ps_rdata,
   input wire logic in_debug,
   input wire logic debug_call_instruction_req,
   input wire logic dbg_int,
   input wire logic [7:0] thread_select,
   input wire logic [4:0] reg_select,
   input wire logic [7:0] thread_run_hold
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   // write data one edge back, so selector checks need no $past on a slice
   logic [31:0] wd_q;
   always_ff @(posedge clk_sys) begin
      wd_q <= ps_req.wdata;
   end
   sequence s_rd(logic [7:0] a);
      ps_req.rd && ps_req.addr == a;
   endsequence
   sequence s_wr(logic [7:0] a);
      in_debug && ps_req.wr && ps_req.addr == a;
   endsequence
   sequence s_call_take;
      !in_debug && debug_call_instruction_req && !dbg_int;
   endsequence
   a_hold_in_debug: assert property (in_debug |-> thread_run_hold == 8'h00)
      else $error("hold vector seen in debug");
   a_unmapped_zero: assert property (s_rd(8'h0B) |=> ps_rdata == 32'h0)
      else $error("unmapped read not zero");
   a_cell_upper_zero: assert property (s_rd(8'h09) |=> ps_rdata[31:16] == 16'h0)
      else $error("cell count upper half set");
   a_wire_upper_zero: assert property (s_rd(8'h0A) |=> ps_rdata[31:16] == 16'h0)
      else $error("wire count upper half set");
   a_mem_size_value: assert property (s_rd(8'h0C) |=> ps_rdata == `DSR_MEM_BYTES)
      else $error("memory size wrong");
   a_ssr_reserved_zero: assert property (s_rd(8'h10) |=> ps_rdata[31:11] == 0 && !ps_rdata[5])
      else $error("status reserved bits set");
   a_call_entry_taken: assert property (s_call_take |=> dbg_int ##1 !dbg_int)
      else $error("call entry not taken as pulse");
   a_entry_refused_debug: assert property (in_debug ##1 1'b1 |-> !dbg_int)
      else $error("entry taken in debug");
   a_tsel_write_value: assert property (s_wr(8'h13) |=> thread_select == wd_q[7:0])
      else $error("thread selector not loaded");
   a_rsel_write_value: assert property (s_wr(8'h14) |=> reg_select == wd_q[4:0])
      else $error("register selector not loaded");
endmodule // dsr_bank_checker

bind dsr_debug_status_bank dsr_bank_checker u_chk (
   .clk_sys(clk_sys),
   .reset(reset),
   .ps_req(ps_req),
   .ps_rdata(ps_rdata),
   .in_debug(in_debug),
   .debug_call_instruction_req(debug_call_instruction_req),
   .dbg_int(dbg_int),
   .thread_select(thread_select),
   .reg_select(reg_select),
   .thread_run_hold(thread_run_hold)
);

/* File: dsr_osc_src.sv */
`timescale 1ns/100ps
// ********
// ring oscillator source
// ********
module dsr_osc_src (
   input wire logic run,
   output logic [1:0] osc_pin
);
   initial osc_pin = 2'b00;
   // periods unrelated to the core clock; a stopped oscillator holds its level
   always #7.3 if (run) osc_pin[0] = ~osc_pin[0];
   always #11.7 if (run) osc_pin[1] = ~osc_pin[1];
endmodule // dsr_osc_src

/* File: dsr_debug_status_bank_bench.sv */
`timescale 1ns/100ps
`include "dsr_map.svh"
// ********
// bench
// ********
module dsr_debug_status_bank_bench
   import dsr_pkg::*;
;
   localparam logic [31:0] CAUSE_EXP [5] = '{32'h1, 32'h0702, 32'h0000_0203, 32'h0002_0504, 32'h0001_0605};
   logic clk_sys, reset, in_debug, host_dbg_req, debug_call_instruction_req, exec_valid, dbg_int, cfg_scr_wr, osc_run;
   logic [1:0] osc_pin;
   logic [2:0] exec_thread, cfg_scr_idx;
   logic [7:0] debug_call_instruction_thread, thread_select, thread_run_hold;
   logic [4:0] reg_select;
   logic [31:0] ps_rdata, exec_pc, cfg_scr_wdata, cfg_scr_rdata, v0, v1;
   dsr_ps_req_s ps_req;
   dsr_ctx_s entry_ctx;
   dsr_watch_s dwatch, rwatch;
   int errors, total_checks;
   dsr_debug_status_bank u_dut (.clk_sys(clk_sys), .reset(reset), .ps_req(ps_req), .ps_rdata(ps_rdata),
      .in_debug(in_debug), .osc_pin(osc_pin), .entry_ctx(entry_ctx), .host_dbg_req(host_dbg_req),
      .debug_call_instruction_req(debug_call_instruction_req), .debug_call_instruction_thread(debug_call_instruction_thread), .exec_valid(exec_valid), .exec_pc(exec_pc),
      .exec_thread(exec_thread), .dwatch(dwatch), .rwatch(rwatch), .dbg_int(dbg_int),
      .thread_select(thread_select), .reg_select(reg_select), .thread_run_hold(thread_run_hold),
      .cfg_scr_wr(cfg_scr_wr), .cfg_scr_idx(cfg_scr_idx), .cfg_scr_wdata(cfg_scr_wdata),
      .cfg_scr_rdata(cfg_scr_rdata));
   dsr_osc_src u_osc (.run(osc_run), .osc_pin(osc_pin));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // ********
   // tasks
   // ********
   task end_sim();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one-cycle strobes; the lowering edge never meets the next raise
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      ps_req.addr <= a;
      ps_req.wdata <= d;
      ps_req.wr <= 1'b1;
      @(posedge clk_sys);
      ps_req.wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      ps_req.addr <= a;
      ps_req.rd <= 1'b1;
      @(posedge clk_sys);
      ps_req.rd <= 1'b0;
      #1 d = ps_rdata;
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
      logic [31:0] d;
      rd(a, d);
      check(name, d, exp);
   endtask
   // raise one entry cause outside debug, then return to debug mode
   task trig(input int k);
      int n;
      @(posedge clk_sys);
      in_debug <= 1'b0;
      case (k)
         1: begin host_dbg_req <= 1'b1; debug_call_instruction_req <= 1'b1; end // host outranks call
         2: debug_call_instruction_req <= 1'b1;
         3: exec_valid <= 1'b1;
         4: dwatch <= '{1'b1, 2'd2, 8'h05, 32'hDEAD_0004};
         default: rwatch <= '{1'b1, 2'd1, 8'h06, 32'h0000_0C01};
      endcase
      for (n = 0; n < 20 && dbg_int !== 1'b1; n++) begin
         @(posedge clk_sys);
         #1;
      end
      if (n == 20) begin
         errors++;
         end_sim();
      end
      @(posedge clk_sys);
      {host_dbg_req, debug_call_instruction_req, exec_valid} <= 3'b000;
      dwatch <= '0;
      rwatch <= '0;
      in_debug <= 1'b1;
   endtask
   // ********
   // sequence
   // ********
   initial begin
      {reset, in_debug, host_dbg_req, debug_call_instruction_req, exec_valid, cfg_scr_wr, osc_run} = 7'b1000001;
      ps_req = '0;
      entry_ctx = '{32'hFFFF_FFFF, 32'h1234_5678, 32'h0000_ABCD, 8'h03};
      debug_call_instruction_thread = 8'h07;
      exec_pc = 32'h100;
      exec_thread = 3'd2;
      dwatch = '0;
      rwatch = '0;
      cfg_scr_idx = 3'd0;
      cfg_scr_wdata = '0;
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      rd_chk(8'h15, 32'h0, "cause_reset");
      rd_chk(8'h0C, `DSR_MEM_BYTES, "mem_size");
      rd_chk(8'h0B, 32'h0, "unmapped");
      wr(8'h13, 32'h1A5);
      rd_chk(8'h13, 32'h0, "tsel_refused");
      @(posedge clk_sys) in_debug <= 1'b1;
      wr(8'h13, 32'h1A5);
      rd_chk(8'h13, 32'hA5, "tsel");
      check("tsel_port", {24'h0, thread_select}, 32'hA5);
      wr(8'h14, 32'hFF);
      rd_chk(8'h14, 32'h1F, "rsel");
      wr(8'h10, 32'hFFFF_FFFF);
      rd_chk(8'h10, 32'h6DF, "ssr_write");
      for (int i = 0; i < 2; i++) begin
         wr(8'h11 + i, 32'hA5A5_0F0F ^ i);
         rd_chk(8'h11 + i, 32'hA5A5_0F0F ^ i, "spc_ssp");
      end
      for (int i = 0; i < 8; i++) wr(8'h20 + i, 32'hC0DE_0000 + i);
      for (int i = 0; i < 8; i++) rd_chk(8'h20 + i, 32'hC0DE_0000 + i, "scratch");
      @(posedge clk_sys) cfg_scr_idx <= 3'd3;
      repeat (2) @(posedge clk_sys);
      #1 check("cfg_scr_rdata", cfg_scr_rdata, 32'hC0DE_0003);
      @(posedge clk_sys);
      {cfg_scr_wr, cfg_scr_idx, cfg_scr_wdata} <= {1'b1, 3'd5, 32'h0BAD_F00D};
      @(posedge clk_sys) cfg_scr_wr <= 1'b0;
      rd_chk(8'h25, 32'h0BAD_F00D, "cfg_scr_write");
      for (int i = 0; i < 4; i++) wr(8'h30 + i, (i == 1) ? 32'h100 : 32'h200 + i);
      for (int i = 0; i < 4; i++) rd_chk(8'h30 + i, (i == 1) ? 32'h100 : 32'h200 + i, "iba");
      wr(8'h40, 32'hFFFF_FFFF);
      rd_chk(8'h40, 32'h00FF_0003, "ibc_mask");
      wr(8'h40, 32'h0004_0003);
      wr(8'h41, 32'h0004_0001);
      wr(8'h18, 32'h124);
      rd_chk(8'h18, 32'h24, "hold");
      check("hold_in_debug", {24'h0, thread_run_hold}, 32'h0);
      @(posedge clk_sys) in_debug <= 1'b0;
      #1 check("hold_out_debug", {24'h0, thread_run_hold}, 32'h24);
      @(posedge clk_sys) in_debug <= 1'b1;
      wr(8'h18, 32'h0);
      for (int k = 1; k <= 5; k++) begin
         trig(k);
         rd_chk(8'h15, CAUSE_EXP[k-1], "cause");
         rd_chk(8'h10, 32'h7DF, "ssr_capture");
         rd_chk(8'h11, 32'h1234_5678, "spc_capture");
         rd_chk(8'h12, 32'h0000_ABCD, "ssp_capture");
         if (k > 3) rd_chk(8'h16, (k == 4) ? 32'hDEAD_0004 : 32'h0C01, "event_data");
      end
      wr(8'h10, 32'h0);
      rd_chk(8'h10, 32'h100, "ssr_ro_bit");
      @(posedge clk_sys) osc_run <= 1'b0;
      repeat (10) @(posedge clk_sys);
      rd(8'h09, v0);
      rd(8'h0A, v1);
      check("cell_upper", v0 & 32'hFFFF_0000, 32'h0);
      check("wire_upper", v1 & 32'hFFFF_0000, 32'h0);
      check("cell_counting", {31'h0, v0[15:0] == 16'h0}, 32'h0);
      check("wire_counting", {31'h0, v1[15:0] == 16'h0}, 32'h0);
      @(posedge clk_sys) reset <= 1'b1;
      @(posedge clk_sys) reset <= 1'b0;
      rd_chk(8'h09, v0, "cell_kept");
      rd_chk(8'h0A, v1, "wire_kept");
      rd_chk(8'h13, 32'h0, "tsel_reset");
      end_sim();
   end
endmodule // dsr_debug_status_bank_bench
